// ---- rtl/omsp_top.sv ----
// Operand store: accumulator pads, main data memory and table memory
`timescale 1ns/10ps
`default_nettype none
module omsp_top #(
  parameter int MEM_AW      = omsp_pkg::MEM_AW,
  parameter int TM_AW       = omsp_pkg::TM_AW,
  parameter bit TM_WRITABLE = 1'b0
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire omsp_pkg::omsp_ctl_t           CTL,
  input  wire logic [omsp_pkg::SPAD_W-1:0]   SCALAR_ALU_OUT_RAW,
  input  wire omsp_pkg::omsp_word_t          ADDER_RESULT,
  input  wire omsp_pkg::omsp_word_t          MULTIPLIER_RESULT,
  input  wire omsp_pkg::omsp_word_t          CONST_VALUE,
  input  wire logic [omsp_pkg::HOST_W-1:0]   HOST_INPUT_BUS,
  output omsp_pkg::omsp_word_t               ADDER_INPUT_ONE,
  output omsp_pkg::omsp_word_t               ADDER_INPUT_TWO,
  output omsp_pkg::omsp_word_t               MULTIPLIER_INPUT_ONE,
  output omsp_pkg::omsp_word_t               MULTIPLIER_INPUT_TWO,
  output omsp_pkg::omsp_word_t               PAD_READ_X,
  output omsp_pkg::omsp_word_t               PAD_READ_Y,
  output omsp_pkg::omsp_word_t               MEM_READ_REG,
  output omsp_pkg::omsp_word_t               TABLE_OUT_REG,
  output omsp_pkg::omsp_word_t               MEM_WRITE_STAGING,
  output logic [omsp_pkg::PAD_AW-1:0]        PAD_BASE_REG,
  output logic [MEM_AW-1:0]                  MEM_ADDR_REG,
  output logic [TM_AW-1:0]                   TABLE_ADDR_REG,
  output logic                               STALL
);

  localparam int PW = omsp_pkg::PAD_AW;
  localparam int WW = omsp_pkg::WORD_W;
  localparam int SW = omsp_pkg::SPAD_W;

  // Registers
  logic [PW-1:0]       pad_base_q;    // Pad base pointer
  logic [MEM_AW-1:0]   ma_q;          // Memory address
  logic [TM_AW-1:0]    tma_q;         // Table address
  omsp_pkg::omsp_word_t mi_q;         // Write staging
  omsp_pkg::omsp_word_t md_q;         // Memory read result
  omsp_pkg::omsp_word_t mstage_q;     // Memory return pipe stage
  omsp_pkg::omsp_word_t tm_q;         // Table output
  omsp_pkg::omsp_word_t a1_q, a2_q, m1_q, m2_q; // Operand registers
  logic go_q;        // Memory cycle started last edge, also busy
  logic wr_q;        // Started cycle is a write
  logic rdv1_q;      // Read in flight, first return stage
  logic rdv2_q;      // Read in flight, second return stage
  logic tgo_q;       // Table read issued last edge
  logic tvld_q;      // Table word for that read now in the ram register
  logic fft_q;       // Table address latched in FFT mode
  logic tneg_q;      // Fold says negate
  logic tzero_q;     // Fold says exact zero

  // Pad and store read data
  omsp_pkg::omsp_word_t pad_x_rd, pad_y_rd, mem_rd, tm_rd;

  // Scalar output after the selected shift
  logic [SW-1:0] scalar_alu_out;
  assign scalar_alu_out = (CTL.scalar_alu_out_shift == omsp_pkg::SH_LEFT1)  ? {SCALAR_ALU_OUT_RAW[SW-2:0], 1'b0} :
                (CTL.scalar_alu_out_shift == omsp_pkg::SH_RIGHT1) ? {1'b0, SCALAR_ALU_OUT_RAW[SW-1:1]} :
                (CTL.scalar_alu_out_shift == omsp_pkg::SH_RIGHT2) ? {2'b00, SCALAR_ALU_OUT_RAW[SW-1:2]} :
                SCALAR_ALU_OUT_RAW;

  // Scalar as a word: integer n is n/2^15 times 2^15, exact
  omsp_pkg::omsp_word_t scalar_alu_out_word;
  assign scalar_alu_out_word = '{expo: omsp_pkg::SCAL_EXP,
                       frac: {scalar_alu_out, 12'h000}};
  // Host bus integer, rounded to 28 fraction bits
  omsp_pkg::omsp_word_t host_word;
  assign host_word = omsp_pkg::host_to_word(HOST_INPUT_BUS);

  // Memory lockout: any start while busy freezes the whole instruction
  logic mem_req, hold, run;
  assign mem_req = CTL.ma_op != omsp_pkg::STEP_HOLD;
  assign hold    = mem_req & go_q;
  assign run     = ~hold;

  // Common address step
  function automatic logic [SW-1:0] step(input omsp_pkg::omsp_step_t op,
                                         input logic [SW-1:0] cur,
                                         input logic [SW-1:0] ld);
    unique case (op)
      omsp_pkg::STEP_LOAD: step = ld;
      omsp_pkg::STEP_INC:  step = cur + 16'h0001;
      omsp_pkg::STEP_DEC:  step = cur - 16'h0001;
      default:             step = cur;
    endcase
  endfunction

  // Next address values; high bits of the scalar fall away on purpose
  logic [SW-1:0] base_nx, ma_nx, tma_nx;
  assign base_nx = step(CTL.base_op, SW'(pad_base_q), scalar_alu_out);
  assign ma_nx   = step(CTL.ma_op,   SW'(ma_q),       scalar_alu_out);
  assign tma_nx  = step(CTL.tma_op,  SW'(tma_q),      scalar_alu_out);

  // Effective pad addresses wrap modulo the bank size
  logic [PW-1:0] rdx_a, rdy_a, wrx_a, wry_a;
  assign rdx_a = pad_base_q + {{(PW-3){CTL.rdx_idx[2]}}, CTL.rdx_idx};
  assign rdy_a = pad_base_q + {{(PW-3){CTL.rdy_idx[2]}}, CTL.rdy_idx};
  assign wrx_a = pad_base_q + {{(PW-3){CTL.wrx_idx[2]}}, CTL.wrx_idx};
  assign wry_a = pad_base_q + {{(PW-3){CTL.wry_idx[2]}}, CTL.wry_idx};

  // Pad write source select
  function automatic omsp_pkg::omsp_word_t pw_mux(
    input omsp_pkg::omsp_pwsel_t sel,
    input omsp_pkg::omsp_word_t  fa, fm, sc, cv, px, py, md, tm);
    unique case (sel)
      omsp_pkg::PW_ADD:   pw_mux = fa;
      omsp_pkg::PW_MUL:   pw_mux = fm;
      omsp_pkg::PW_SCAL:  pw_mux = sc;
      omsp_pkg::PW_CONST: pw_mux = cv;
      omsp_pkg::PW_PADX:  pw_mux = px;
      omsp_pkg::PW_PADY:  pw_mux = py;
      omsp_pkg::PW_MEMRD: pw_mux = md;
      omsp_pkg::PW_TABLE: pw_mux = tm;
    endcase
  endfunction

  omsp_pkg::omsp_word_t wrx_data, wry_data;
  assign wrx_data = pw_mux(CTL.wrx_sel, ADDER_RESULT, MULTIPLIER_RESULT,
                           scalar_alu_out_word, CONST_VALUE, pad_x_rd, pad_y_rd,
                           md_q, tm_q);
  assign wry_data = pw_mux(CTL.wry_sel, ADDER_RESULT, MULTIPLIER_RESULT,
                           scalar_alu_out_word, CONST_VALUE, pad_x_rd, pad_y_rd,
                           md_q, tm_q);

  // Staging register source select; unused codes keep the old word
  omsp_pkg::omsp_word_t mi_src;
  always_comb
  begin
    unique case (CTL.mi_sel)
      omsp_pkg::MI_ADD:   mi_src = ADDER_RESULT;
      omsp_pkg::MI_MUL:   mi_src = MULTIPLIER_RESULT;
      omsp_pkg::MI_PADX:  mi_src = pad_x_rd;
      omsp_pkg::MI_PADY:  mi_src = pad_y_rd;
      omsp_pkg::MI_MEMRD: mi_src = md_q;
      omsp_pkg::MI_TABLE: mi_src = tm_q;
      omsp_pkg::MI_HOST:  mi_src = host_word;
      omsp_pkg::MI_SCAL:  mi_src = scalar_alu_out_word;
      omsp_pkg::MI_CONST: mi_src = CONST_VALUE;
      default:            mi_src = mi_q;
    endcase
  end

  // First and second operand selects
  function automatic omsp_pkg::omsp_word_t opa(
    input omsp_pkg::omsp_opa_t  sel,
    input omsp_pkg::omsp_word_t px, py, tm);
    unique case (sel)
      omsp_pkg::OPA_PADX:  opa = px;
      omsp_pkg::OPA_PADY:  opa = py;
      omsp_pkg::OPA_TABLE: opa = tm;
      default:             opa = '0;
    endcase
  endfunction

  function automatic omsp_pkg::omsp_word_t opb(
    input omsp_pkg::omsp_opb_t  sel,
    input omsp_pkg::omsp_word_t px, py, md);
    unique case (sel)
      omsp_pkg::OPB_PADX:  opb = px;
      omsp_pkg::OPB_PADY:  opb = py;
      omsp_pkg::OPB_MEMRD: opb = md;
      default:             opb = '0;
    endcase
  endfunction

  // Pad banks: one read and one write port each, old data on collision
  omsp_ram #(.W(WW), .AW(PW), .WRITABLE(1'b1)) u_pad_bank_x (
    .clk   (CLK),
    .rst_n (RST_N),
    .we    (CTL.wrx_en & run),
    .waddr (wrx_a),
    .wdata (wrx_data),
    .raddr (rdx_a),
    .rdata (pad_x_rd)
  );

  omsp_ram #(.W(WW), .AW(PW), .WRITABLE(1'b1)) u_pad_bank_y (
    .clk   (CLK),
    .rst_n (RST_N),
    .we    (CTL.wry_en & run),
    .waddr (wry_a),
    .wdata (wry_data),
    .raddr (rdy_a),
    .rdata (pad_y_rd)
  );

  // Main data memory; write commits from the staging register
  omsp_ram #(.W(WW), .AW(MEM_AW), .WRITABLE(1'b1)) u_main_mem (
    .clk   (CLK),
    .rst_n (RST_N),
    .we    (go_q & wr_q),
    .waddr (ma_q),
    .wdata (mi_q),
    .raddr (ma_q),
    .rdata (mem_rd)
  );

  // FFT fold: quadrant in top two bits, index mirrored in odd quadrants
  logic [1:0]       quad;
  logic [TM_AW-3:0] kidx, kfold;
  logic [TM_AW-1:0] tm_raddr;
  assign quad     = tma_q[TM_AW-1:TM_AW-2];
  assign kidx     = tma_q[TM_AW-3:0];
  assign kfold    = quad[0] ? (~kidx + 1'b1) : kidx;
  assign tm_raddr = fft_q ? {2'b00, kfold} : tma_q;

  // Table store; written only when the writable option is built
  omsp_ram #(.W(WW), .AW(TM_AW), .WRITABLE(TM_WRITABLE)) u_table_mem (
    .clk   (CLK),
    .rst_n (RST_N),
    .we    (CTL.tm_wr & run),
    .waddr (tma_q),
    .wdata (mi_q),
    .raddr (tm_raddr),
    .rdata (tm_rd)
  );

  // Table value after sign fold; negating the most negative saturates
  omsp_pkg::omsp_word_t tm_fix;
  logic [omsp_pkg::FRAC_W-1:0] tm_negf;
  assign tm_negf = (tm_rd.frac == omsp_pkg::FRAC_MIN) ? omsp_pkg::FRAC_MAX
                                                      : (~tm_rd.frac + 1'b1);
  assign tm_fix  = tzero_q ? '0 :
                   tneg_q  ? {tm_rd.expo, tm_negf} : tm_rd;

  // Address registers and staging register; frozen during lockout
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pad_base_q <= '0;
      ma_q       <= '0;
      tma_q      <= '0;
      mi_q       <= '0;
      fft_q      <= 1'b0;
    end
    else if (run)
    begin
      pad_base_q <= base_nx[PW-1:0];
      ma_q       <= ma_nx[MEM_AW-1:0];
      tma_q      <= tma_nx[TM_AW-1:0];
      if (CTL.mi_ld)
        mi_q <= mi_src;
      if (CTL.tma_op != omsp_pkg::STEP_HOLD)
        fft_q <= CTL.fft_mode;
    end
  end

  // Memory sequencing: start, write flag and read return pipe
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      go_q   <= 1'b0;
      wr_q   <= 1'b0;
      rdv1_q <= 1'b0;
      rdv2_q <= 1'b0;
    end
    else
    begin
      go_q   <= mem_req & run;
      wr_q   <= CTL.mi_ld;
      rdv1_q <= go_q & ~wr_q;
      rdv2_q <= rdv1_q;
    end
  end

  // Read return: third edge after the request loads the data register
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mstage_q <= '0;
      md_q     <= '0;
    end
    else
    begin
      mstage_q <= mem_rd;
      if (rdv2_q)
        md_q <= mstage_q;
    end
  end

  // Table sequencing: any address change is a request, one per cycle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tgo_q   <= 1'b0;
      tvld_q  <= 1'b0;
      tneg_q  <= 1'b0;
      tzero_q <= 1'b0;
      tm_q    <= '0;
    end
    else
    begin
      tgo_q   <= run & (CTL.tma_op != omsp_pkg::STEP_HOLD);
      // Ram reads the new address one edge late, so wait a second edge
      tvld_q  <= tgo_q;
      tneg_q  <= fft_q & (quad[1] ^ quad[0]);
      tzero_q <= fft_q & quad[0] & (kidx == '0);
      if (tvld_q)
        tm_q <= tm_fix;
    end
  end

  // Operand registers for the arithmetic pipelines
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      a1_q <= '0;
      a2_q <= '0;
      m1_q <= '0;
      m2_q <= '0;
    end
    else if (run)
    begin
      a1_q <= opa(CTL.a1_sel, pad_x_rd, pad_y_rd, tm_q);
      a2_q <= opb(CTL.a2_sel, pad_x_rd, pad_y_rd, md_q);
      m1_q <= opa(CTL.m1_sel, pad_x_rd, pad_y_rd, tm_q);
      m2_q <= opb(CTL.m2_sel, pad_x_rd, pad_y_rd, md_q);
    end
  end

  // Outputs, all from flops
  assign ADDER_INPUT_ONE      = a1_q;
  assign ADDER_INPUT_TWO      = a2_q;
  assign MULTIPLIER_INPUT_ONE = m1_q;
  assign MULTIPLIER_INPUT_TWO = m2_q;
  assign PAD_READ_X           = pad_x_rd;
  assign PAD_READ_Y           = pad_y_rd;
  assign MEM_READ_REG         = md_q;
  assign TABLE_OUT_REG        = tm_q;
  assign MEM_WRITE_STAGING    = mi_q;
  assign PAD_BASE_REG         = pad_base_q;
  assign MEM_ADDR_REG         = ma_q;
  assign TABLE_ADDR_REG       = tma_q;
  assign STALL                = go_q;

endmodule
`default_nettype wire

// ---- shared/omsp_pkg.sv ----
// Shared constants, word format, control types and conversion helper
`default_nettype none
package omsp_pkg;

  // Word layout: exponent occupies the high end, fraction the low end
  localparam int WORD_W   = 38;
  localparam int EXP_W    = 10;
  localparam int FRAC_W   = 28;
  localparam logic [EXP_W-1:0] EXP_BIAS = 10'h200;

  // Pad geometry
  localparam int PAD_WORDS = 32;
  localparam int PAD_AW    = 5;
  localparam int IDX_W     = 3;

  // Scalar path and default memory sizes
  localparam int SPAD_W    = 16;
  localparam int MEM_WORDS = 8192;
  localparam int MEM_AW    = 13;
  localparam int TM_AW     = 10;
  localparam int HOST_W    = 32;

  // Integer-to-word conversion exponents and rounding
  localparam logic [EXP_W-1:0] SCAL_EXP = EXP_BIAS + 10'h00f;
  localparam logic [EXP_W-1:0] HOST_EXP = EXP_BIAS + 10'h01f;
  localparam int               DROP_W   = 4;
  localparam logic [DROP_W-1:0] RND_HALF = 4'h8;
  localparam logic [FRAC_W-1:0] FRAC_MAX = 28'h7ffffff;
  localparam logic [FRAC_W-1:0] FRAC_MIN = 28'h8000000;

  // Latencies in machine cycles
  localparam int MEM_RD_LAT = 3;
  localparam int TM_RD_LAT  = 2;

  // One floating word: exponent first, two's complement fraction after
  typedef struct packed {
    logic [EXP_W-1:0]  expo;
    logic [FRAC_W-1:0] frac;
  } omsp_word_t;

  // Address register actions
  typedef enum logic [1:0] {STEP_HOLD, STEP_LOAD, STEP_INC, STEP_DEC}
    omsp_step_t;

  // Scalar ALU shifter settings
  typedef enum logic [1:0] {SH_NONE, SH_LEFT1, SH_RIGHT1, SH_RIGHT2}
    omsp_shift_t;

  // Pad write sources
  typedef enum logic [2:0] {PW_ADD, PW_MUL, PW_SCAL, PW_CONST,
                            PW_PADX, PW_PADY, PW_MEMRD, PW_TABLE}
    omsp_pwsel_t;

  // Staging register sources
  typedef enum logic [3:0] {MI_ADD, MI_MUL, MI_PADX, MI_PADY, MI_MEMRD,
                            MI_TABLE, MI_HOST, MI_SCAL, MI_CONST}
    omsp_misel_t;

  // First operand sources (adder one, multiplier one)
  typedef enum logic [1:0] {OPA_ZERO, OPA_PADX, OPA_PADY, OPA_TABLE}
    omsp_opa_t;

  // Second operand sources (adder two, multiplier two)
  typedef enum logic [1:0] {OPB_ZERO, OPB_PADX, OPB_PADY, OPB_MEMRD}
    omsp_opb_t;

  // One instruction's worth of operand-store control
  typedef struct packed {
    omsp_step_t             base_op;
    logic signed [IDX_W-1:0] rdx_idx;
    logic signed [IDX_W-1:0] rdy_idx;
    logic signed [IDX_W-1:0] wrx_idx;
    logic signed [IDX_W-1:0] wry_idx;
    logic                   wrx_en;
    logic                   wry_en;
    omsp_pwsel_t            wrx_sel;
    omsp_pwsel_t            wry_sel;
    omsp_step_t             ma_op;
    logic                   mi_ld;
    omsp_misel_t            mi_sel;
    omsp_step_t             tma_op;
    logic                   tm_wr;
    logic                   fft_mode;
    omsp_shift_t            scalar_alu_out_shift;
    omsp_opa_t              a1_sel;
    omsp_opb_t              a2_sel;
    omsp_opa_t              m1_sel;
    omsp_opb_t              m2_sel;
  } omsp_ctl_t;

  // Host integer to word; round only when remainder exceeds half an LSB
  function automatic omsp_word_t host_to_word(input logic [HOST_W-1:0] n);
    omsp_word_t w;
    w.expo = HOST_EXP;
    w.frac = n[HOST_W-1:DROP_W];
    if (n[DROP_W-1:0] > RND_HALF && w.frac != FRAC_MAX)
      w.frac = w.frac + 28'h0000001;
    return w;
  endfunction

endpackage
`default_nettype wire

// ---- rtl/omsp_ram.sv ----
// Simple dual-port word store with registered read data
`timescale 1ns/10ps
`default_nettype none
module omsp_ram #(
  parameter int W        = 38,
  parameter int AW       = 5,
  parameter bit WRITABLE = 1'b1
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  // Storage array, not reset
  logic [W-1:0] mem [2**AW];

  // Read output register; clears so the port is defined from reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else
      rdata <= mem[raddr];
  end

  // Write port; a same-cycle read above still sees the old word
  always_ff @(posedge clk)
  begin
    if (we && WRITABLE)
      mem[waddr] <= wdata;
  end

endmodule
`default_nettype wire

// ---- verification/omsp_top_properties.sv ----
// Concurrent checks on the operand store top-level ports
`timescale 1ns/10ps
`default_nettype none
module omsp_top_properties #(
  parameter int MEM_AW = omsp_pkg::MEM_AW,
  parameter int TM_AW  = omsp_pkg::TM_AW
) (
  input wire logic                        CLK,
  input wire logic                        RST_N,
  input wire omsp_pkg::omsp_ctl_t         CTL,
  input wire omsp_pkg::omsp_word_t        CONST_VALUE,
  input wire omsp_pkg::omsp_word_t        PAD_READ_X,
  input wire omsp_pkg::omsp_word_t        ADDER_INPUT_ONE,
  input wire omsp_pkg::omsp_word_t        MULTIPLIER_INPUT_ONE,
  input wire omsp_pkg::omsp_word_t        MULTIPLIER_INPUT_TWO,
  input wire omsp_pkg::omsp_word_t        MEM_READ_REG,
  input wire omsp_pkg::omsp_word_t        TABLE_OUT_REG,
  input wire omsp_pkg::omsp_word_t        MEM_WRITE_STAGING,
  input wire logic [omsp_pkg::PAD_AW-1:0] PAD_BASE_REG,
  input wire logic [MEM_AW-1:0]           MEM_ADDR_REG,
  input wire logic [TM_AW-1:0]            TABLE_ADDR_REG,
  input wire logic                        STALL
);
  logic frz;    // Whole instruction refused by lockout
  logic mstart; // Accepted memory start
  logic rstart; // Accepted memory read start
  logic tstart; // Accepted table read
  assign frz    = CTL.ma_op != omsp_pkg::STEP_HOLD && STALL;
  assign mstart = CTL.ma_op != omsp_pkg::STEP_HOLD && !STALL;
  assign rstart = mstart && !CTL.mi_ld;
  assign tstart = CTL.tma_op != omsp_pkg::STEP_HOLD && !frz;
  // One clock domain, reset disables everything
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Busy exactly one cycle, then free again
  sequence s_busy_once;
    STALL ##1 !STALL;
  endsequence
  a_busy_one_cycle: assert property (mstart |=> s_busy_once)
    else $error("busy window wrong after memory start");
  a_frozen_regs: assert property (frz |=> $stable(PAD_BASE_REG)
    && $stable(MEM_ADDR_REG) && $stable(TABLE_ADDR_REG)
    && $stable(MEM_WRITE_STAGING))
    else $error("refused instruction changed a register");
  a_ma_hold: assert property (CTL.ma_op == omsp_pkg::STEP_HOLD
    |=> $stable(MEM_ADDR_REG))
    else $error("memory address moved without a step");
  a_ma_step_up: assert property (mstart && CTL.ma_op == omsp_pkg::STEP_INC
    |=> MEM_ADDR_REG == $past(MEM_ADDR_REG) + 1'b1)
    else $error("memory address increment wrong");
  a_base_step_down: assert property (!frz
    && CTL.base_op == omsp_pkg::STEP_DEC
    |=> PAD_BASE_REG == $past(PAD_BASE_REG) - 1'b1)
    else $error("pad base decrement wrong");
  // Outputs only move two or three cycles after a request
  a_table_quiet: assert property (!tstart |=> ##2 $stable(TABLE_OUT_REG))
    else $error("table output changed without a request");
  a_mem_quiet: assert property (!rstart |=> ##3 $stable(MEM_READ_REG))
    else $error("memory data changed without a read");
  a_stage_const: assert property (CTL.mi_ld && !frz
    && CTL.mi_sel == omsp_pkg::MI_CONST
    |=> MEM_WRITE_STAGING == $past(CONST_VALUE))
    else $error("staging did not take the constant");
  a_a1_from_pad: assert property (CTL.a1_sel == omsp_pkg::OPA_PADX && !frz
    |=> ADDER_INPUT_ONE == $past(PAD_READ_X))
    else $error("adder input one not from pad x");
  a_m2_from_mem: assert property (CTL.m2_sel == omsp_pkg::OPB_MEMRD && !frz
    |=> MULTIPLIER_INPUT_TWO == $past(MEM_READ_REG))
    else $error("multiplier input two not from memory data");
  a_m1_from_tab: assert property (CTL.m1_sel == omsp_pkg::OPA_TABLE && !frz
    |=> MULTIPLIER_INPUT_ONE == $past(TABLE_OUT_REG))
    else $error("multiplier input one not from table");
endmodule

bind omsp_top omsp_top_properties #(.MEM_AW(MEM_AW), .TM_AW(TM_AW)) u_props (
  .CLK(CLK), .RST_N(RST_N), .CTL(CTL), .CONST_VALUE(CONST_VALUE),
  .PAD_READ_X(PAD_READ_X), .ADDER_INPUT_ONE(ADDER_INPUT_ONE),
  .MULTIPLIER_INPUT_ONE(MULTIPLIER_INPUT_ONE),
  .MULTIPLIER_INPUT_TWO(MULTIPLIER_INPUT_TWO),
  .MEM_READ_REG(MEM_READ_REG), .TABLE_OUT_REG(TABLE_OUT_REG),
  .MEM_WRITE_STAGING(MEM_WRITE_STAGING), .PAD_BASE_REG(PAD_BASE_REG),
  .MEM_ADDR_REG(MEM_ADDR_REG), .TABLE_ADDR_REG(TABLE_ADDR_REG),
  .STALL(STALL)
);
`default_nettype wire

// ---- verification/omsp_arith_model.sv ----
// Behavioural adder and multiplier pipelines facing the operand store
`timescale 1ns/10ps
`default_nettype none
module omsp_arith_model (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire omsp_pkg::omsp_word_t a_one,
  input  wire omsp_pkg::omsp_word_t m_one,
  output omsp_pkg::omsp_word_t      fa,
  output omsp_pkg::omsp_word_t      fm
);
  omsp_pkg::omsp_word_t a_buf_q; // Adder buffer stage
  omsp_pkg::omsp_word_t m_b2_q;  // Multiplier second stage
  omsp_pkg::omsp_word_t m_b3_q;  // Multiplier third stage
  // Results echo input one; arithmetic itself is outside this block
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      a_buf_q <= '0;
      fa      <= '0;
      m_b2_q  <= '0;
      m_b3_q  <= '0;
      fm      <= '0;
    end
    else
    begin
      a_buf_q <= a_one;
      fa      <= a_buf_q;
      m_b2_q  <= m_one;
      m_b3_q  <= m_b2_q;
      fm      <= m_b3_q;
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the operand store
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                 clk;       // Machine clock
  logic                 rst_n;     // Active-low reset
  omsp_pkg::omsp_ctl_t  ctl;       // Instruction fields
  logic [15:0]          scalar_alu_out;      // Scalar result before shift
  logic [31:0]          host;      // Host input bus
  omsp_pkg::omsp_word_t cval;      // Command constant
  omsp_pkg::omsp_word_t fa, fm;    // Partner results
  omsp_pkg::omsp_word_t a1, a2, m1, m2, px, py, md, tm, mi;
  logic [4:0]           base;      // Pad base
  logic [12:0]          ma;        // Memory address
  logic [9:0]           table_addr_reg;       // Table address
  logic                 stall;     // Lockout flag
  int                   err_total; // Mismatch count
  int                   checked;   // Comparison count
  // Writable table so the bench can load it
  omsp_top #(.TM_WRITABLE(1'b1)) dut (
    .CLK(clk), .RST_N(rst_n), .CTL(ctl), .SCALAR_ALU_OUT_RAW(scalar_alu_out),
    .ADDER_RESULT(fa), .MULTIPLIER_RESULT(fm), .CONST_VALUE(cval),
    .HOST_INPUT_BUS(host), .ADDER_INPUT_ONE(a1), .ADDER_INPUT_TWO(a2),
    .MULTIPLIER_INPUT_ONE(m1), .MULTIPLIER_INPUT_TWO(m2),
    .PAD_READ_X(px), .PAD_READ_Y(py), .MEM_READ_REG(md),
    .TABLE_OUT_REG(tm), .MEM_WRITE_STAGING(mi), .PAD_BASE_REG(base),
    .MEM_ADDR_REG(ma), .TABLE_ADDR_REG(table_addr_reg), .STALL(stall)
  );
  omsp_arith_model u_arith (
    .clk(clk), .rst_n(rst_n), .a_one(a1), .m_one(m1), .fa(fa), .fm(fm)
  );
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Present one instruction at a rising edge
  task automatic issue(input omsp_pkg::omsp_ctl_t c,
                       input omsp_pkg::omsp_word_t v = '0,
                       input logic [15:0] s = '0,
                       input logic [31:0] h = '0);
    @(posedge clk);
    ctl  <= c;
    cval <= v;
    scalar_alu_out <= s;
    host <= h;
  endtask
  // Let one edge pass and its updates settle
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Distinct word per index
  function automatic omsp_pkg::omsp_word_t w(input int i);
    return {omsp_pkg::EXP_BIAS, 28'(i + 256)};
  endfunction
  // Address registers, lockout flag and memory data cleared right after reset
  task automatic t_reset;
    chk(38'({base, ma, table_addr_reg, stall}), 38'h0);
    chk(md, 38'h0);
  endtask
  // Pad banks: indexed writes, reads, same-cycle access, base step
  task automatic t_pad;
    omsp_pkg::omsp_ctl_t c;
    c = '0;
    c.base_op = omsp_pkg::STEP_LOAD;
    issue(c, '0, 16'h0004);
    for (int i = -4; i < 4; i++)
    begin
      c = '0;
      c.wrx_en = 1'b1;
      c.wry_en = 1'b1;
      c.wrx_idx = 3'(i);
      c.wry_idx = 3'(i);
      c.wrx_sel = omsp_pkg::PW_CONST;
      c.wry_sel = omsp_pkg::PW_SCAL;
      issue(c, w(i), 16'(i + 512));
    end
    for (int i = -4; i < 4; i++)
    begin
      c = '0;
      c.rdx_idx = 3'(i);
      c.rdy_idx = 3'(i);
      issue(c);
      issue('0);
      #1;
      chk(px, w(i));
      chk(py, {omsp_pkg::SCAL_EXP, 16'(i + 512), 12'h000});
    end
    // Write and read of one location in one cycle
    c = '0;
    c.wrx_en = 1'b1;
    c.wrx_sel = omsp_pkg::PW_CONST;
    issue(c, w(50));
    c = '0;
    c.a1_sel = omsp_pkg::OPA_PADX;
    issue(c);
    #1;
    chk(px, w(0));
    issue('0);
    #1;
    chk(px, w(50));
    chk(a1, w(0));
    // Base steps down, read uses the new base
    c = '0;
    c.base_op = omsp_pkg::STEP_DEC;
    issue(c);
    c = '0;
    c.rdx_idx = -3'sd3;
    issue(c);
    issue('0);
    #1;
    chk(px, w(-4));
    chk(38'(base), 38'h3);
  endtask
  // Main memory: write, refused start, reads three cycles late
  task automatic t_mem;
    omsp_pkg::omsp_ctl_t c;
    c = '0;
    c.ma_op = omsp_pkg::STEP_LOAD;
    c.mi_ld = 1'b1;
    c.mi_sel = omsp_pkg::MI_CONST;
    issue(c, w(7), 16'h0040);
    c.ma_op = omsp_pkg::STEP_INC;
    issue(c, w(9));
    #1;
    chk(38'(stall), 38'h1);
    issue(c, w(9));
    #1;
    chk(38'(ma), 38'h40);
    chk(mi, w(7));
    issue('0);
    #1;
    chk(38'(ma), 38'h41);
    chk(38'(stall), 38'h1);
    c = '0;
    c.ma_op = omsp_pkg::STEP_LOAD;
    issue(c, '0, 16'h0040);
    issue('0);
    tick;
    tick;
    chk(md, 38'h0);
    tick;
    chk(md, w(7));
    c.ma_op = omsp_pkg::STEP_INC;
    issue(c);
    c = '0;
    c.a2_sel = omsp_pkg::OPB_MEMRD;
    c.m2_sel = omsp_pkg::OPB_MEMRD;
    issue(c);
    tick;
    tick;
    tick;
    chk(md, w(9));
    tick;
    chk(a2, w(9));
    chk(m2, w(9));
    issue('0);
  endtask
  // Table: load writable store, back-to-back reads, angle mode
  task automatic t_table;
    omsp_pkg::omsp_ctl_t c;
    omsp_pkg::omsp_ctl_t cw;
    c = '0;
    cw = '0;
    cw.tm_wr = 1'b1;
    c.tma_op = omsp_pkg::STEP_LOAD;
    c.mi_ld = 1'b1;
    c.mi_sel = omsp_pkg::MI_CONST;
    issue(c, w(21), 16'h0005);
    issue(cw);
    c.tma_op = omsp_pkg::STEP_INC;
    issue(c, w(22));
    issue(cw);
    c = '0;
    c.tma_op = omsp_pkg::STEP_LOAD;
    issue(c, '0, 16'h0005);
    c.tma_op = omsp_pkg::STEP_INC;
    issue(c);
    c.tma_op = omsp_pkg::STEP_LOAD;
    c.fft_mode = 1'b1;
    issue(c, '0, 16'h0205);
    // Table operand taken only once defined words reach the output
    c = '0;
    c.m1_sel = omsp_pkg::OPA_TABLE;
    issue(c);
    #1;
    chk(tm, w(21));
    tick;
    chk(tm, w(22));
    chk(m1, w(21));
    tick;
    // Third quadrant gives the negated entry five
    chk(tm, w(-533));
  endtask
  // Host rounding and scalar shifter into staging
  task automatic t_conv;
    omsp_pkg::omsp_ctl_t c;
    logic [31:0] hv [3] = '{32'h00000128, 32'h00000129, 32'hfffffff9};
    logic [15:0] sv [4] = '{16'h1234, 16'h2468, 16'h091a, 16'h048d};
    c = '0;
    c.mi_ld = 1'b1;
    c.mi_sel = omsp_pkg::MI_HOST;
    for (int k = 0; k < 3; k++)
    begin
      issue(c, '0, '0, hv[k]);
      issue('0);
      #1;
      chk(mi, {omsp_pkg::HOST_EXP, hv[k][31:4] + 28'(hv[k][3:0] > 4'h8)});
    end
    c.mi_sel = omsp_pkg::MI_SCAL;
    for (int k = 0; k < 4; k++)
    begin
      c.scalar_alu_out_shift = omsp_pkg::omsp_shift_t'(k);
      issue(c, '0, 16'h1234);
      issue('0);
      #1;
      chk(mi, {omsp_pkg::SCAL_EXP, sv[k], 12'h000});
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    err_total = 0;
    checked = 0;
    rst_n = 1'b0;
    ctl = '0;
    scalar_alu_out = '0;
    host = '0;
    cval = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_pad;
    t_mem;
    t_table;
    t_conv;
    report_and_stop;
  end
  // Watchdog: the run needs under a hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
